/* File: logic/rrts_consts.vh */
`ifndef RRTS_CONSTS_VH
`define RRTS_CONSTS_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
// Strap sample delay after reset release, in ns
`define RRTS_SAMPLE_DELAY_NS   1500
// Core clock period in ns (25 MHz)
`define RRTS_CLK_PERIOD_NS     40
// Cycles from release to sample: 1500 / 40 rounded down
`define RRTS_SAMPLE_CYCLES     (`RRTS_SAMPLE_DELAY_NS / `RRTS_CLK_PERIOD_NS)
// Cycles spent in self-configuration after the strap sample
`define RRTS_CONFIG_CYCLES     16

// ----------------------------------------------------------------
// Strap layout
// ----------------------------------------------------------------
`define RRTS_STRAP_WIDTH       8
`define RRTS_STRAP_NORMAL      8'h00

// ----------------------------------------------------------------
// Sequencer states
// ----------------------------------------------------------------
`define RRTS_ST_HOLD           2'h0
`define RRTS_ST_WAIT           2'h1
`define RRTS_ST_CONFIG         2'h2
`define RRTS_ST_RUN            2'h3

`endif

/* File: logic/rrts_reset_sync.v */
// ----------------------------------------------------------------
// Two-stage reset release synchroniser
// ----------------------------------------------------------------
module rrts_reset_sync (
    input  wire i_core_clk,
    input  wire i_arst_n,
    output wire o_rst_n
);

    reg meta_q;
    reg sync_q;

    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= 1'b1;
            sync_q <= meta_q;
        end
    end

    assign o_rst_n = sync_q;

endmodule // rrts_reset_sync

/* File: logic/rrts_top.v */

`include "rrts_consts.vh"

module rrts_top #(
    parameter SAMPLE_CYCLES = `RRTS_SAMPLE_CYCLES,
    parameter CONFIG_CYCLES = `RRTS_CONFIG_CYCLES
) (
    input  wire       i_core_clk,
    input  wire       i_arst_n,
    input  wire       i_scan_port_reset_low,
    input  wire       i_manufacturing_test_select,
    input  wire [7:0] i_test_strap_pin,
    input  wire [7:0] i_test_out_data,
    output wire [7:0] o_test_strap_pin,
    output wire [7:0] o_test_strap_pin_oe,
    output reg  [7:0] o_test_mode_sel,
    output reg        o_test_mode_active,
    output reg        o_self_config_busy,
    output reg        o_self_config_done,
    output reg        o_startup_fault
);

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    wire rst_n;

    rrts_reset_sync u_reset_sync (
        .i_core_clk (i_core_clk),
        .i_arst_n   (i_arst_n),
        .o_rst_n    (rst_n)
    );

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    localparam [1:0] ST_HOLD   = `RRTS_ST_HOLD;
    localparam [1:0] ST_WAIT   = `RRTS_ST_WAIT;
    localparam [1:0] ST_CONFIG = `RRTS_ST_CONFIG;
    localparam [1:0] ST_RUN    = `RRTS_ST_RUN;
    localparam integer SAMPLE_LAST_I = SAMPLE_CYCLES - 1;
    localparam integer CONFIG_LAST_I = CONFIG_CYCLES - 1;
    localparam [15:0]  SAMPLE_LAST   = SAMPLE_LAST_I[15:0];
    localparam [15:0]  CONFIG_LAST   = CONFIG_LAST_I[15:0];

    reg  [1:0]  state_q;
    reg  [1:0]  state_d;
    reg  [15:0] cnt_q;
    reg  [15:0] cnt_d;
    reg         started_q;
    reg  [7:0]  strap_q;
    reg         drive_q;
    reg  [7:0]  out_q;
    wire        release_pulse;
    wire        sample_now;
    wire        busy_d;
    wire        done_d;
    wire        active_d;

    // ----------------------------------------------------------------
    // Release edge detect
    // ----------------------------------------------------------------
    // Cleared by the synchronised reset, so the low-to-high release
    // is seen exactly once per power-on reset
    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            started_q <= 1'b0;
        end else begin
            started_q <= 1'b1;
        end
    end

    assign release_pulse = !started_q;

    // ----------------------------------------------------------------
    // Sequencer next state
    // ----------------------------------------------------------------
    // Single compare point, so the straps can only be taken once
    assign sample_now = (state_q == ST_WAIT) && (cnt_q == SAMPLE_LAST);

    always @* begin
        state_d = state_q;
        cnt_d   = cnt_q + 16'h0001;
        case (state_q)
            ST_HOLD: begin
                cnt_d   = 16'h0000;
                if (release_pulse) begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (sample_now) begin
                    cnt_d   = 16'h0000;
                    state_d = ST_CONFIG;
                end
            end
            ST_CONFIG: begin
                if (cnt_q == CONFIG_LAST) begin
                    cnt_d   = 16'h0000;
                    state_d = ST_RUN;
                end
            end
            default: begin
                cnt_d   = cnt_q;
                state_d = ST_RUN;
            end
        endcase
    end

    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_HOLD;
            cnt_q   <= 16'h0000;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // ----------------------------------------------------------------
    // Strap capture and pin drive
    // ----------------------------------------------------------------
    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_q <= `RRTS_STRAP_NORMAL;
        end else if (sample_now) begin
            strap_q <= i_test_strap_pin;
        end
    end

    // Pins stay undriven until the sample has been taken
    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_q <= 1'b0;
        end else if (sample_now) begin
            drive_q <= 1'b1;
        end
    end

    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= 8'h00;
        end else begin
            out_q <= drive_q ? i_test_out_data : 8'h00;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `RRTS_STRAP_WIDTH; g = g + 1) begin : g_pin
            assign o_test_strap_pin[g]    = out_q[g];
            assign o_test_strap_pin_oe[g] = drive_q;
        end
    endgenerate

    // ----------------------------------------------------------------
    // Status outputs
    // ----------------------------------------------------------------
    assign busy_d   = (state_q == ST_WAIT) || (state_q == ST_CONFIG);
    assign done_d   = (state_q == ST_RUN);
    assign active_d = (|strap_q) | i_manufacturing_test_select;

    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_test_mode_sel <= 8'h00;
        end else begin
            o_test_mode_sel <= strap_q;
        end
    end

    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_test_mode_active <= 1'b0;
        end else begin
            o_test_mode_active <= active_d;
        end
    end

    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_self_config_busy <= 1'b0;
        end else begin
            o_self_config_busy <= busy_d;
        end
    end

    // Done holds until the next power-on reset
    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_self_config_done <= 1'b0;
        end else begin
            o_self_config_done <= done_d;
        end
    end

    // A scan reset pin left high is flagged, not obeyed
    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_startup_fault <= 1'b0;
        end else begin
            o_startup_fault <= i_scan_port_reset_low;
        end
    end

endmodule // rrts_top

/* File: tb/rrts_checker.sv */
module rrts_checker #(parameter SAMPLE_CYCLES = 37) (
    input wire       i_core_clk,
    input wire       i_arst_n,
    input wire       i_scan_port_reset_low,
    input wire       i_manufacturing_test_select,
    input wire [7:0] o_test_strap_pin_oe,
    input wire [7:0] o_test_mode_sel,
    input wire       o_test_mode_active,
    input wire       o_self_config_busy,
    input wire       o_self_config_done,
    input wire       o_startup_fault
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    // Cycles since reset release
    logic [7:0] cnt_q;
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n)
            cnt_q <= 8'h00;
        else if (cnt_q != 8'hff)
            cnt_q <= cnt_q + 8'h01;
    end
    property p_quiet; disable iff (1'b0)
        !i_arst_n |-> o_test_strap_pin_oe == 8'h00 && !o_self_config_done; endproperty
    a_quiet: assert property (p_quiet) else $error("output active in reset");
    property p_oe; o_test_strap_pin_oe != 8'h00 |=> o_test_strap_pin_oe == 8'hff; endproperty
    a_oe: assert property (p_oe) else $error("strap drive not held");
    property p_when; $rose(o_test_strap_pin_oe[0])
        |-> cnt_q inside {[SAMPLE_CYCLES:SAMPLE_CYCLES+4]}; endproperty
    a_when: assert property (p_when) else $error("strap sample time");
    property p_sel; o_self_config_done |=> $stable(o_test_mode_sel); endproperty
    a_sel: assert property (p_sel) else $error("mode changed");
    property p_done; o_self_config_done |=> o_self_config_done; endproperty
    a_done: assert property (p_done) else $error("done dropped");
    property p_start; $rose(o_self_config_done) |-> $past(o_self_config_busy); endproperty
    a_start: assert property (p_start) else $error("done without busy");
    property p_mode; o_self_config_done && $stable(i_manufacturing_test_select)
        |-> o_test_mode_active == (|o_test_mode_sel || i_manufacturing_test_select); endproperty
    a_mode: assert property (p_mode) else $error("test mode wrong");
    property p_fault; o_self_config_done
        |-> o_startup_fault == $past(i_scan_port_reset_low); endproperty
    a_fault: assert property (p_fault) else $error("fault flag wrong");
endmodule // rrts_checker

bind rrts_top rrts_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (.i_core_clk, .i_arst_n,
    .i_scan_port_reset_low, .i_manufacturing_test_select, .o_test_strap_pin_oe,
    .o_test_mode_sel, .o_test_mode_active, .o_self_config_busy, .o_self_config_done,
    .o_startup_fault);

/* File: tb/rrts_pmic_model.sv */
module rrts_pmic_model (
    input  wire       i_core_clk,
    input  wire       i_hold,
    input  wire [7:0] i_pull,
    input  wire [7:0] i_pin_out,
    input  wire [7:0] i_pin_oe,
    output logic      o_arst_n = 1'h0,
    output wire [7:0] o_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Reset moves only on a running clock edge
    always @(posedge i_core_clk) o_arst_n <= #1 !i_hold;
    // Undriven pins settle to the pull level: 0 weak pulldown, 1 board pullup
    assign o_pin = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_pull);
endmodule // rrts_pmic_model

/* File: tb/test_reset_release_test_strap.sv */
module test_reset_release_test_strap;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'h0, hold = 1'h1, mfg = 1'h0, scan = 1'h0, rst_n, act, busy, done, flt;
    logic [7:0] pull = 8'h00, tdat = 8'h3c, pin, pout, oe, sel;
    int         failures = 0, cmp_count = 0, cyc = 0;
    initial forever #20 clk = ~clk;
    rrts_pmic_model u_pmic (.i_core_clk(clk), .i_hold(hold), .i_pull(pull),
        .i_pin_out(pout), .i_pin_oe(oe), .o_arst_n(rst_n), .o_pin(pin));
    rrts_top u_dut (.i_core_clk(clk), .i_arst_n(rst_n), .i_scan_port_reset_low(scan),
        .i_manufacturing_test_select(mfg), .i_test_strap_pin(pin), .i_test_out_data(tdat),
        .o_test_strap_pin(pout), .o_test_strap_pin_oe(oe), .o_test_mode_sel(sel),
        .o_test_mode_active(act), .o_self_config_busy(busy), .o_self_config_done(done),
        .o_startup_fault(flt));
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic print_verdict;
        if (failures == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic t_abort;
        hold = 1'h0;
        step(20);
        hold = 1'h1;
        step(2);
        chk("oe_abort", 8'h00, oe);
        chk("sel_abort", 8'h00, sel);
    endtask
    task automatic t_boot(input logic [7:0] st, input logic m, input logic s);
        hold = 1'h1;
        pull = st;
        mfg = m;
        scan = s;
        step(2);
        chk("oe_rst", 8'h00, oe);
        hold = 1'h0;
        step(30);
        chk("oe_early", 8'h00, oe);
        chk("busy", 8'h01, busy);
        for (int i = 0; i < 60 && done !== 1'h1; i++) step(1);
        pull = ~st;
        step(2);
        chk("sel", st, sel);
        chk("act", {7'h00, |st | m}, act);
        chk("oe", 8'hff, oe);
        chk("pin", tdat, pout);
        chk("flt", {7'h00, s}, flt);
        chk("done", 8'h01, done);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            print_verdict;
        end
    end
    initial begin
        step(2);
        chk("oe_q", 8'h00, oe);
        chk("done_q", 8'h00, done);
        t_abort;
        t_boot(8'h00, 1'h0, 1'h0);
        t_boot(8'ha5, 1'h0, 1'h1);
        t_boot(8'h80, 1'h1, 1'h0);
        print_verdict;
    end
endmodule // test_reset_release_test_strap
